//--- pkg/edpo_pkg.sv
// package for the encoder divided pulse output block: map, layouts, types
`default_nettype none
package edpo_pkg;
	// register offsets (byte addresses, one word each)
	localparam logic [4:0] EDPO_ADDR_CTRL = 5'h00;
	localparam logic [4:0] EDPO_ADDR_PULSES = 5'h04;
	localparam logic [4:0] EDPO_ADDR_LINRES = 5'h08;
	localparam logic [4:0] EDPO_ADDR_ENCRES = 5'h0C;
	localparam logic [4:0] EDPO_ADDR_PITCH = 5'h10;
	localparam logic [4:0] EDPO_ADDR_STATUS = 5'h14;
	// control word bit positions
	localparam int EDPO_CTRL_DIR_BIT = 0;
	localparam int EDPO_CTRL_CBOTH_BIT = 1;
	localparam int EDPO_CTRL_LINEAR_BIT = 2;
	localparam int EDPO_CTRL_DUAL_BIT = 3;
	localparam int EDPO_CTRL_CNTDIR_BIT = 4;
	localparam int EDPO_CTRL_RESTART_BIT = 8;
	// reset values of the settings
	localparam logic [30:0] EDPO_PULSES_RST = 31'h0000_0800;
	localparam logic [12:0] EDPO_LINRES_RST = 13'h0014;
	localparam logic [31:0] EDPO_ENCRES_RST = 32'h0010_0000;
	localparam logic [31:0] EDPO_PITCH_RST = 32'h0000_1000;
	// quadrature edges per output pulse, as a shift
	localparam int EDPO_EDGE_SHIFT = 2;
	// origin offset in both-direction mode: divider modulus (pitch or counts per revolution) shifted right by this
	localparam int EDPO_EIGHTH_SHIFT = 3;
	// origin pulse width in divided edges (one phase-A high time)
	localparam logic [1:0] EDPO_C_WIDTH = 2'h2;

	// configuration applied at restart
	typedef struct packed {
		logic dir_sel;          // reversed movement direction
		logic c_both;           // origin pulses in both directions
		logic linear;           // linear motor / scale
		logic dual_origin;      // scale with direction-dependent mark
		logic count_dir_mode;   // origin follows scale count direction
		logic [30:0] pulses;    // output pulses per revolution
		logic [12:0] linres;    // output edges per scale pitch
		logic [31:0] encres;    // internal counts per revolution
		logic [31:0] pitchres;  // internal counts per scale pitch
	} edpo_cfg_t;

	// internal encoder events, same clock domain
	typedef struct packed {
		logic step;        // one internal position count
		logic count_up;    // raw scale count direction
		logic origin;      // origin mark seen
		logic origin_alt;  // second mark position of some scales
	} edpo_enc_t;

	// output pin group, true and inverted lines
	typedef struct packed {
		logic a;
		logic a_n;
		logic b;
		logic b_n;
		logic c;
		logic c_n;
	} edpo_pins_t;

	// whole state of the block
	typedef struct packed {
		edpo_cfg_t cfg_sh;   // written settings, not yet active
		edpo_cfg_t cfg_act;  // settings in force
		logic [31:0] acc;    // divider remainder
		logic [1:0] q;       // quadrature position index
		logic armed;         // forward origin crossing seen
		logic [1:0] c_cnt;   // edges left in origin pulse
		logic pend;          // delayed origin pending
		logic pend_fwd;      // direction of the pending origin
		logic [31:0] off_cnt; // counts left before delayed origin
		logic [31:0] rdata;  // read data register
		edpo_pins_t pins;    // registered outputs
	} edpo_state_t;
endpackage : edpo_pkg
`default_nettype wire

//--- rtl/edpo_top.sv
// encoder divided pulse output: quadrature A/B and origin C generator
//
// Overview of operation
// - phases A and B a quarter cycle apart
// - forward B leads A, reverse A leads B
// - rotary: configured pulse count per revolution
// - linear: configured edges per scale pitch
// - one origin pulse per revolution
// - origin pulse as wide as phase A
// - reversed direction keeps the phase relationship
// - origin direction select, applied at restart
// - both-direction origin pulse may be narrower
// - both-direction origin shifted one eighth pitch (one eighth revolution when rotary)
// - dual-mark scales give origin at two positions
// - first origin only on forward crossing
// - divide internal counts by output pulse count
`default_nettype none
module edpo_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clk_en,
	input wire edpo_pkg::edpo_enc_t enc,
	input wire logic [4:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic phase_a_out,
	output logic phase_a_out_n,
	output logic phase_b_out,
	output logic phase_b_out_n,
	output logic origin_pulse_out,
	output logic origin_pulse_out_n
);

	// quadrature index to {A,B}: 0->00 1->01 2->11 3->10
	function automatic logic [1:0] edpo_gray(input logic [1:0] idx);
		edpo_gray = {idx[1], idx[1] ^ idx[0]};
	endfunction : edpo_gray

	// drive all six pins from one quadrature index and origin level
	function automatic edpo_pkg::edpo_pins_t edpo_pack(
		input logic [1:0] idx,
		input logic c
	);
		logic [1:0] ab;
		ab = edpo_gray(idx);
		edpo_pack.a = ab[1];
		edpo_pack.a_n = ~ab[1];
		edpo_pack.b = ab[0];
		edpo_pack.b_n = ~ab[0];
		edpo_pack.c = c;
		edpo_pack.c_n = ~c;
	endfunction : edpo_pack

	// settings as they stand after reset
	function automatic edpo_pkg::edpo_cfg_t edpo_cfg_rst();
		edpo_cfg_rst.dir_sel = 1'b0;
		edpo_cfg_rst.c_both = 1'b0;
		edpo_cfg_rst.linear = 1'b0;
		edpo_cfg_rst.dual_origin = 1'b0;
		edpo_cfg_rst.count_dir_mode = 1'b0;
		edpo_cfg_rst.pulses = edpo_pkg::EDPO_PULSES_RST;
		edpo_cfg_rst.linres = edpo_pkg::EDPO_LINRES_RST;
		edpo_cfg_rst.encres = edpo_pkg::EDPO_ENCRES_RST;
		edpo_cfg_rst.pitchres = edpo_pkg::EDPO_PITCH_RST;
	endfunction : edpo_cfg_rst

	// reset image of the whole state
	function automatic edpo_pkg::edpo_state_t edpo_state_rst();
		edpo_state_rst.cfg_sh = edpo_cfg_rst();
		edpo_state_rst.cfg_act = edpo_cfg_rst();
		edpo_state_rst.acc = 32'h0000_0000;
		edpo_state_rst.q = 2'h0;
		edpo_state_rst.armed = 1'b0;
		edpo_state_rst.c_cnt = 2'h0;
		edpo_state_rst.pend = 1'b0;
		edpo_state_rst.pend_fwd = 1'b0;
		edpo_state_rst.off_cnt = 32'h0000_0000;
		edpo_state_rst.rdata = 32'h0000_0000;
		edpo_state_rst.pins = edpo_pack(2'h0, 1'b0);
	endfunction : edpo_state_rst

	// current and next state
	edpo_pkg::edpo_state_t st_ff;
	edpo_pkg::edpo_state_t nxt_st;

	// divider step size and modulus, widened to avoid overflow
	logic [32:0] div_inc;
	logic [32:0] div_mod;
	logic [32:0] div_sum;
	// motion sense seen by the phases and by the origin logic
	logic motion_fwd;
	logic org_fwd;
	logic org_hit;
	logic org_ok;
	// one divided quadrature edge this cycle and its direction
	logic div_edge;
	logic div_fwd;
	// origin pulse start request
	logic c_fire;

	// the whole block is one state struct: every branch below edits nxt_st or a temporary
	// that is set on every pass, so a missed assignment keeps the old value, never a latch
	// encoder events come from logic on mclk, so nothing is synchronised;
	// a pin-level encoder would need two flip-flops in front of enc
	// next-state logic: bus, divider, quadrature, origin
	always_comb begin
		nxt_st = st_ff;
		div_edge = 1'b0;
		div_fwd = 1'b0;
		c_fire = 1'b0;
		div_sum = 33'h0_0000_0000;
		nxt_st.rdata = 32'h0000_0000;

		// a read that lands while clk_en is low is lost, so the master
		// keeps the enable high for its bus cycles
		// register reads; unmapped offsets read zero
		if (rd) begin
			case (addr)
				edpo_pkg::EDPO_ADDR_CTRL: begin
					nxt_st.rdata[edpo_pkg::EDPO_CTRL_DIR_BIT] =
						st_ff.cfg_sh.dir_sel;
					nxt_st.rdata[edpo_pkg::EDPO_CTRL_CBOTH_BIT] =
						st_ff.cfg_sh.c_both;
					nxt_st.rdata[edpo_pkg::EDPO_CTRL_LINEAR_BIT] =
						st_ff.cfg_sh.linear;
					nxt_st.rdata[edpo_pkg::EDPO_CTRL_DUAL_BIT] =
						st_ff.cfg_sh.dual_origin;
					nxt_st.rdata[edpo_pkg::EDPO_CTRL_CNTDIR_BIT] =
						st_ff.cfg_sh.count_dir_mode;
				end
				edpo_pkg::EDPO_ADDR_PULSES: begin
					nxt_st.rdata = {1'b0, st_ff.cfg_sh.pulses};
				end
				edpo_pkg::EDPO_ADDR_LINRES: begin
					nxt_st.rdata = {19'h0_0000, st_ff.cfg_sh.linres};
				end
				edpo_pkg::EDPO_ADDR_ENCRES: begin
					nxt_st.rdata = st_ff.cfg_sh.encres;
				end
				edpo_pkg::EDPO_ADDR_PITCH: begin
					nxt_st.rdata = st_ff.cfg_sh.pitchres;
				end
				edpo_pkg::EDPO_ADDR_STATUS: begin
					// live state: index, arm flag, origin, pending
					nxt_st.rdata = {27'h000_0000, st_ff.pend,
						st_ff.pins.c, st_ff.armed, st_ff.q};
				end
				default: begin
					nxt_st.rdata = 32'h0000_0000;
				end
			endcase
		end

		// writes other than a restart never touch the live settings, so a half-written
		// configuration cannot reach the pins
		// settings land in the shadow copy only; they act after restart
		if (wr) begin
			case (addr)
				edpo_pkg::EDPO_ADDR_CTRL: begin
					nxt_st.cfg_sh.dir_sel =
						wdata[edpo_pkg::EDPO_CTRL_DIR_BIT];
					nxt_st.cfg_sh.c_both =
						wdata[edpo_pkg::EDPO_CTRL_CBOTH_BIT];
					nxt_st.cfg_sh.linear =
						wdata[edpo_pkg::EDPO_CTRL_LINEAR_BIT];
					nxt_st.cfg_sh.dual_origin =
						wdata[edpo_pkg::EDPO_CTRL_DUAL_BIT];
					nxt_st.cfg_sh.count_dir_mode =
						wdata[edpo_pkg::EDPO_CTRL_CNTDIR_BIT];
				end
				edpo_pkg::EDPO_ADDR_PULSES: begin
					nxt_st.cfg_sh.pulses = wdata[30:0];
				end
				edpo_pkg::EDPO_ADDR_LINRES: begin
					nxt_st.cfg_sh.linres = wdata[12:0];
				end
				edpo_pkg::EDPO_ADDR_ENCRES: begin
					nxt_st.cfg_sh.encres = wdata;
				end
				edpo_pkg::EDPO_ADDR_PITCH: begin
					nxt_st.cfg_sh.pitchres = wdata;
				end
				default: begin
					// read-only or unmapped: write ignored
				end
			endcase
		end

		// rotary: 4 edges per output pulse over counts per revolution
		// linear: edges per pitch over counts per pitch
		if (st_ff.cfg_act.linear) begin
			div_inc = {20'h0_0000, st_ff.cfg_act.linres};
			div_mod = {1'b0, st_ff.cfg_act.pitchres};
		end else begin
			div_inc = {st_ff.cfg_act.pulses, 2'h0};
			div_mod = {1'b0, st_ff.cfg_act.encres};
		end
		// limitation: a zero modulus stops the divider entirely, so
		// software writes a nonzero count before the restart
		// the clamp keeps one edge per count at most, traded for a
		// slower output when the edges asked for (four per pulse) exceed the counts
		// never more than one edge per count, so no state is skipped
		if (div_inc > div_mod) begin
			div_inc = div_mod;
		end

		// direction select flips the count sense, not the pattern
		motion_fwd = enc.count_up ^ st_ff.cfg_act.dir_sel;

		// fractional divider: remainder stays in [0, modulus)
		if (enc.step && (div_mod != 33'h0_0000_0000)) begin
			if (motion_fwd) begin
				div_sum = {1'b0, st_ff.acc} + div_inc;
				if (div_sum >= div_mod) begin
					div_sum = div_sum - div_mod;
					div_edge = 1'b1;
					div_fwd = 1'b1;
				end
			end else begin
				if ({1'b0, st_ff.acc} >= div_inc) begin
					div_sum = {1'b0, st_ff.acc} - div_inc;
				end else begin
					div_sum = {1'b0, st_ff.acc} + div_mod - div_inc;
					div_edge = 1'b1;
				end
			end
			nxt_st.acc = div_sum[31:0];
		end

		// a count that rolls the divider moves the index by exactly one,
		// whichever way it went
		// one gray step per divided edge: forward makes B lead
		if (div_edge) begin
			if (div_fwd) begin
				nxt_st.q = st_ff.q + 2'h1;
			end else begin
				nxt_st.q = st_ff.q - 2'h1;
			end
		end

		// origin pulse ages by divided edges, so it tracks phase A width
		if (div_edge && (st_ff.c_cnt != 2'h0)) begin
			nxt_st.c_cnt = st_ff.c_cnt - 2'h1;
		end

		// forward-only mode on count-sense scales ignores dir select
		if (st_ff.cfg_act.count_dir_mode && !st_ff.cfg_act.c_both) begin
			org_fwd = enc.count_up;
		end else begin
			org_fwd = motion_fwd;
		end
		// second mark of direction-dependent scales also counts
		org_hit = enc.origin ||
			(st_ff.cfg_act.dual_origin && enc.origin_alt);
		// first crossing must be forward; reverse only once armed
		org_ok = org_fwd || (st_ff.cfg_act.c_both && st_ff.armed);

		// the offset makes the both-direction pulse land elsewhere than
		// the forward-only one; a reversal inside the offset swallows
		// that origin altogether
		// delayed origin in both-direction mode: an eighth of the modulus later (pitch when linear, revolution when rotary)
		if (st_ff.pend && enc.step) begin
			if (motion_fwd != st_ff.pend_fwd) begin
				nxt_st.pend = 1'b0; // reversal before the offset: drop
			end else if (st_ff.off_cnt == 32'h0000_0000) begin
				nxt_st.pend = 1'b0;
				c_fire = 1'b1;
			end else begin
				nxt_st.off_cnt = st_ff.off_cnt - 32'h0000_0001;
			end
		end

		// new origin crossing, one per revolution of the encoder
		if (org_hit) begin
			if (org_fwd) begin
				nxt_st.armed = 1'b1;
			end
			if (org_ok) begin
				if (st_ff.cfg_act.c_both) begin
					nxt_st.pend = 1'b1;
					nxt_st.pend_fwd = motion_fwd;
					nxt_st.off_cnt = div_mod[31:0] >>
						edpo_pkg::EDPO_EIGHTH_SHIFT;
				end else begin
					c_fire = 1'b1;
				end
			end
		end

		// a new start beats the ageing above
		if (c_fire) begin
			nxt_st.c_cnt = edpo_pkg::EDPO_C_WIDTH;
		end

		// restart: settings take effect, origin tracking starts over
		if (wr && (addr == edpo_pkg::EDPO_ADDR_CTRL) &&
			wdata[edpo_pkg::EDPO_CTRL_RESTART_BIT]) begin
			nxt_st.cfg_act = nxt_st.cfg_sh;
			// the index is kept so the host count does not jump
			nxt_st.acc = 32'h0000_0000;
			// a forward crossing in this same cycle still arms
			nxt_st.armed = org_hit && org_fwd;
			// a pending offset belongs to the old settings: drop it
			nxt_st.pend = 1'b0;
			// a pulse starting in this cycle wins over the clear
			if (!c_fire) begin
				nxt_st.c_cnt = 2'h0;
			end
		end

		// both lines of a pair are registered together from one next-state value, so the
		// complement cannot lag its true line by a cycle
		// pins from the next index, true and inverted together
		nxt_st.pins = edpo_pack(nxt_st.q, nxt_st.c_cnt != 2'h0);
	end

	// reset beats the enable, so a frozen block can still be cleared
	// state register; clock enable low freezes everything
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff <= edpo_state_rst();
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end

	// every pin is a flip-flop output, so the host sees no glitch when
	// the index and the origin level change in the same cycle
	// outputs straight from the registered pin group
	assign rdata = st_ff.rdata;
	assign phase_a_out = st_ff.pins.a;
	assign phase_a_out_n = st_ff.pins.a_n;
	assign phase_b_out = st_ff.pins.b;
	assign phase_b_out_n = st_ff.pins.b_n;
	assign origin_pulse_out = st_ff.pins.c;
	assign origin_pulse_out_n = st_ff.pins.c_n;

endmodule : edpo_top
`default_nettype wire

//--- testbench/edpo_monitor.sv
// checker for the divided pulse pins and the read port
`default_nettype none
module edpo_monitor (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clk_en,
	input wire edpo_pkg::edpo_enc_t enc,
	input wire logic [4:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic phase_a_out,
	input wire logic phase_a_out_n,
	input wire logic phase_b_out,
	input wire logic phase_b_out_n,
	input wire logic origin_pulse_out,
	input wire logic origin_pulse_out_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// one domain, so clock and reset are given once
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// inverted lines must mirror the true lines
	chk_a_compl: assert property (phase_a_out_n == !phase_a_out)
		else $error("phase a pair not complementary");
	chk_b_compl: assert property (phase_b_out_n == !phase_b_out)
		else $error("phase b pair not complementary");
	chk_c_compl: assert property (origin_pulse_out_n == !origin_pulse_out)
		else $error("origin pair not complementary");
	// a skipped gray state shows as both phases moving together
	chk_gray_one: assert property (!($changed(phase_a_out) &&
		$changed(phase_b_out))) else $error("both phases moved at once");
	// no divided edge without an accepted encoder count
	chk_ab_cause: assert property ($changed(phase_a_out) ||
		$changed(phase_b_out) |-> $past(enc.step && clk_en))
		else $error("phase edge without a count");
	// origin width is counted in divided edges, so it ends on one
	// a restart clears a running pulse off any edge, so skip that case
	chk_c_fall: assert property ($fell(origin_pulse_out) &&
		!$past(wr) |-> $changed(phase_a_out) || $changed(phase_b_out))
		else $error("origin pulse ended off an edge");
	// pins and read data idle after reset
	chk_reset_idle: assert property ($fell(rst) |-> !phase_a_out &&
		!phase_b_out && !origin_pulse_out && rdata == 32'h0)
		else $error("outputs not idle after reset");
	// read data stands one cycle only
	chk_rd_idle: assert property (!rd && clk_en |=> rdata == 32'h0)
		else $error("read data without a read");
	chk_rd_unmap: assert property (rd && clk_en && addr > 5'h14 |=>
		rdata == 32'h0) else $error("unmapped read not zero");
	// a held enable freezes read data and both phases
	chk_en_freeze: assert property (!clk_en |=> $stable(rdata) &&
		$stable(phase_a_out) && $stable(phase_b_out))
		else $error("outputs moved while disabled");
	cov_origin: cover property ($rose(origin_pulse_out));
	cov_read: cover property (rd ##1 rdata != 32'h0);
	cov_fwd: cover property ($rose(phase_b_out) && !phase_a_out);
endmodule : edpo_monitor
bind edpo_top edpo_monitor edpo_monitor_i (.mclk(mclk), .rst(rst),
	.clk_en(clk_en), .enc(enc), .addr(addr), .wr(wr), .rd(rd),
	.rdata(rdata),
	.phase_a_out(phase_a_out), .phase_a_out_n(phase_a_out_n),
	.phase_b_out(phase_b_out), .phase_b_out_n(phase_b_out_n),
	.origin_pulse_out(origin_pulse_out),
	.origin_pulse_out_n(origin_pulse_out_n));
`default_nettype wire

//--- testbench/edpo_host_model.sv
// host side quadrature counter: position, origin count, origin width
`default_nettype none
module edpo_host_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic a,
	input wire logic b,
	input wire logic c,
	output var int pos,
	output var int n_org,
	output var int c_wid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] prev_ab; // pin pair one cycle ago
	logic prev_c; // origin level one cycle ago
	logic [1:0] d; // gray index step this cycle
	int run_wid; // edges seen while origin high
	// gray index: 00,01,11,10 climbs when b leads
	function automatic logic [1:0] gidx(input logic [1:0] ab);
		return {ab[1], ab[1] ^ ab[0]};
	endfunction : gidx
	// gray index step between the last sample and now
	always_comb begin
		d = gidx({a, b}) - gidx(prev_ab);
	end
	// count like a real host: only legal single steps move position
	always @(posedge mclk) begin
		prev_ab <= {a, b};
		prev_c <= c;
		if (rst) begin
			pos <= 0;
			n_org <= 0;
			c_wid <= 0;
			run_wid <= 0;
		end else begin
			if (d == 2'h1) pos <= pos + 1;
			else if (d == 2'h3) pos <= pos - 1;
			if (c && !prev_c) n_org <= n_org + 1;
			if (c && !prev_c) run_wid <= 0;
			else if (prev_c && d != 2'h0) run_wid <= run_wid + 1;
			if (prev_c && !c) c_wid <= run_wid + int'(d != 2'h0);
		end
	end
endmodule : edpo_host_model
`default_nettype wire

//--- testbench/edpo_tb_top.sv
// self-checking bench for the divided pulse output block
`default_nettype none
module edpo_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst, clk_en, wr, rd, pend_rd;
	edpo_pkg::edpo_enc_t enc;
	logic [4:0] addr;
	logic [31:0] wdata, rdata;
	logic pa, pa_n, pb, pb_n, pc, pc_n; // pin group
	int pos, n_org, c_wid; // host model counts
	int p0, n0; // counts before a scenario
	int n_mismatch = 0;
	int check_count = 0;
	logic [31:0] exp_q[$]; // expected read answers, oldest first
	edpo_top edpo_top_i (.mclk(mclk), .rst(rst), .clk_en(clk_en),
		.enc(enc), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .phase_a_out(pa), .phase_a_out_n(pa_n),
		.phase_b_out(pb), .phase_b_out_n(pb_n), .origin_pulse_out(pc),
		.origin_pulse_out_n(pc_n));
	edpo_host_model edpo_host_model_i (.mclk(mclk), .rst(rst), .a(pa),
		.b(pb), .c(pc), .pos(pos), .n_org(n_org), .c_wid(c_wid));
	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// compare one value and report a mismatch at once
	task automatic cmp(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask : cmp
	// verdict and end of run
	task automatic close_out();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	// one-cycle write, then a quiet cycle so strobes never collide
	task automatic bus_wr(input logic [4:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask : bus_wr
	// one-cycle read; the answer is noted for the watcher
	task automatic bus_rd(input logic [4:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(posedge mclk);
	endtask : bus_rd
	// counts two cycles apart; gaps wobble the enable at random
	// org bit 0 is the main mark, bit 1 the second mark of a scale
	task automatic step(input int n, input logic up, input logic [1:0] org);
		for (int i = 0; i < n; i++) begin
			enc <= '{1'b1, up, org[0] && i == 0, org[1] && i == 0};
			clk_en <= 1'b1;
			@(posedge mclk);
			enc <= '{1'b0, up, 1'b0, 1'b0};
			clk_en <= 1'($urandom_range(0, 1));
			@(posedge mclk);
		end
		clk_en <= 1'b1;
		@(posedge mclk);
	endtask : step
	// answer watcher: read data is sampled in its one valid cycle
	always @(posedge mclk) begin
		pend_rd <= rd && clk_en && !rst;
		if (pend_rd) begin
			cmp("rdata", exp_q.pop_front(), rdata);
		end
	end
	// main sequence
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		enc = '0;
		addr = 5'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		void'($urandom(32'h4d28));
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		cmp("a_n idle", 32'h1, 32'(pa_n));
		bus_rd(5'h1C, 32'h0);
		bus_rd(edpo_pkg::EDPO_ADDR_PULSES, 32'(edpo_pkg::EDPO_PULSES_RST));
		// 32 counts per rev, 4 pulses per rev: one edge every 2 counts
		bus_wr(edpo_pkg::EDPO_ADDR_ENCRES, 32'h20);
		bus_wr(edpo_pkg::EDPO_ADDR_PULSES, 32'h4);
		bus_wr(edpo_pkg::EDPO_ADDR_CTRL, 32'h100);
		step(64, 1'b1, 1'b0);
		cmp("pos fwd", 32'h20, 32'(pos));
		step(32, 1'b0, 1'b0);
		cmp("pos rev", 32'h10, 32'(pos));
		step(6, 1'b0, 1'b1);
		cmp("org rev first", 32'h0, 32'(n_org));
		step(6, 1'b1, 1'b1);
		cmp("org fwd", 32'h1, 32'(n_org));
		cmp("org width", 32'h2, 32'(c_wid));
		step(6, 1'b0, 1'b1);
		cmp("org rev fwd only", 32'h1, 32'(n_org));
		// restart into both directions; arming starts again
		bus_wr(edpo_pkg::EDPO_ADDR_CTRL, 32'h102);
		step(8, 1'b0, 1'b1);
		cmp("org rev unarmed", 32'h1, 32'(n_org));
		step(8, 1'b1, 1'b1);
		cmp("org fwd both", 32'h2, 32'(n_org));
		step(8, 1'b0, 1'b1);
		cmp("org rev both", 32'h3, 32'(n_org));
		// the last origin pulse is still one divided edge from its end
		bus_rd(edpo_pkg::EDPO_ADDR_STATUS, 32'hC | (32'(pos) & 32'h3));
		// reversed direction select: up counts run backwards, and an
		// origin met that way is a reverse crossing, so it stays quiet
		bus_wr(edpo_pkg::EDPO_ADDR_CTRL, 32'h101);
		p0 = pos;
		n0 = n_org;
		step(8, 1'b1, 2'h1);
		cmp("pos dir_sel", 32'hFFFF_FFFC, 32'(pos - p0));
		cmp("org dir_sel", 32'h0, 32'(n_org - n0));
		// count-direction mode: the raw up count makes it forward
		bus_wr(edpo_pkg::EDPO_ADDR_CTRL, 32'h111);
		step(4, 1'b1, 2'h1);
		cmp("org count dir", 32'h1, 32'(n_org - n0));
		// dual-mark scale: the second mark alone gives an origin
		bus_wr(edpo_pkg::EDPO_ADDR_CTRL, 32'h108);
		step(4, 1'b1, 2'h2);
		cmp("org second mark", 32'h2, 32'(n_org - n0));
		// linear: 10 edges per 40-count pitch, one edge per 4 counts
		bus_wr(edpo_pkg::EDPO_ADDR_PITCH, 32'h28);
		bus_wr(edpo_pkg::EDPO_ADDR_LINRES, 32'hA);
		bus_wr(edpo_pkg::EDPO_ADDR_CTRL, 32'h104);
		bus_rd(edpo_pkg::EDPO_ADDR_LINRES, 32'hA);
		p0 = pos;
		step(16, 1'b1, 2'h0);
		cmp("pos linear", 32'h4, 32'(pos - p0));
		repeat (2) @(posedge mclk);
		close_out();
	end
	// watchdog, far past the few hundred cycles the tests need
	initial begin
		#100us;
		n_mismatch++;
		close_out();
	end
endmodule : edpo_tb_top
`default_nettype wire
